// >>> pdsm_map.vh
// constants for the program/data space mapper
`ifndef PDSM_MAP_VH
`define PDSM_MAP_VH
`define PDSM_OFF_CTRL      12'h000
`define PDSM_OFF_WIN_PAGE  12'h004
`define PDSM_OFF_TBL_PAGE  12'h008
`define PDSM_OFF_STATUS    12'h00C
`define PDSM_CTRL_WIN_EN   0
`define PDSM_STAT_BUSY     0
`define PDSM_STAT_TBL      1
`define PDSM_STAT_WIN      2
`define PDSM_PAGE_RST      8'h00
`define PDSM_CTRL_RST      1'b0
`define PDSM_Y_BASE_RST    16'h0800
`define PDSM_Y_END_RST     16'h1000
`define PDSM_RAM_END_RST   16'h2000
`define PDSM_XHALF_BASE    16'h8000
`define PDSM_WAIT_SHORT    2'd1
`define PDSM_WAIT_LONG     2'd2
`endif

// >>> pdsm_mapper.v
// program/data space mapper: table access, program window, x/y routing
`timescale 1ns/1ps
`include "pdsm_map.vh"
module pdsm_mapper #(
  parameter [15:0] Y_BASE  = `PDSM_Y_BASE_RST,
  parameter [15:0] Y_END   = `PDSM_Y_END_RST,
  parameter [15:0] RAM_END = `PDSM_RAM_END_RST
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        ce_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire        hsel_i,
  input  wire        hready_i,
  input  wire [31:0] hwdata_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  input  wire        req_valid_i,
  input  wire [2:0]  req_op_i,
  input  wire        req_byte_i,
  input  wire        req_mac_i,
  input  wire        req_short_i,
  input  wire [1:0]  req_rep_i,
  input  wire [15:0] x_addr_i,
  input  wire [15:0] y_addr_i,
  input  wire        y_valid_i,
  input  wire        x_bitrev_i,
  input  wire        x_modulo_i,
  input  wire        y_modulo_i,
  input  wire [15:0] wdata_i,
  input  wire [23:0] prog_rdata_i,
  input  wire [15:0] xram_rdata_i,
  input  wire [15:0] yram_rdata_i,
  output reg  [23:0] prog_addr_o,
  output reg         prog_rd_o,
  output reg         prog_wr_lo_o,
  output reg         prog_wr_hi_o,
  output reg  [15:0] prog_wdata_o,
  output reg  [15:0] xram_addr_o,
  output reg         xram_rd_o,
  output reg         xram_wr_o,
  output reg  [1:0]  xram_be_o,
  output reg  [15:0] xram_wdata_o,
  output reg         x_bitrev_o,
  output reg         x_modulo_o,
  output reg  [15:0] yram_addr_o,
  output reg         yram_rd_o,
  output reg         y_modulo_o,
  output reg  [15:0] x_rdata_o,
  output reg  [15:0] y_rdata_o,
  output reg  [1:0]  stall_o,
  output reg         rdata_valid_o
);
  // request opcodes
  localparam [2:0] OP_RD   = 3'd0;
  localparam [2:0] OP_WR   = 3'd1;
  localparam [2:0] OP_TRDL = 3'd2;
  localparam [2:0] OP_TRDH = 3'd3;
  localparam [2:0] OP_TWTL = 3'd4;
  localparam [2:0] OP_TWTH = 3'd5;
  localparam [2:0] OP_ACCW = 3'd6;
  // repeat position
  localparam [1:0] REP_NONE = 2'd0;
  localparam [1:0] REP_EDGE = 2'd1;
  localparam [1:0] REP_MID  = 2'd2;
  // read-return lane selectors
  localparam [2:0] SEL_RAM  = 3'd0;
  localparam [2:0] SEL_WIN  = 3'd1;
  localparam [2:0] SEL_TLO  = 3'd2;
  localparam [2:0] SEL_THI  = 3'd3;
  localparam [2:0] SEL_ZERO = 3'd4;

  reg        win_en_q;
  reg [7:0]  win_page_q;
  reg [7:0]  tbl_page_q;
  reg        tbl_busy_q;
  reg        last_win_q;
  reg        last_tbl_q;
  reg [2:0]  sel_q;
  reg        byte_q;
  reg        bsel_q;
  reg        ybad_q;
  reg        yrd_q;
  reg        bus_ph_q;
  reg        bus_wr_q;
  reg [11:0] bus_addr_q;

  function in_y;
    input [15:0] a;
    begin
      in_y = (a >= Y_BASE) && (a < Y_END);
    end
  endfunction

  function implemented;
    input [15:0] a;
    begin
      implemented = a < RAM_END;
    end
  endfunction

  // register slots, shared by the write and the read decode
  localparam [2:0] SLOT_NONE = 3'd0;
  localparam [2:0] SLOT_CTRL = 3'd1;
  localparam [2:0] SLOT_WPG  = 3'd2;
  localparam [2:0] SLOT_TPG  = 3'd3;
  localparam [2:0] SLOT_STAT = 3'd4;

  function [2:0] reg_slot;
    input [11:0] a;
    begin
      case (a & 12'hFFC)
        `PDSM_OFF_CTRL:     reg_slot = SLOT_CTRL;
        `PDSM_OFF_WIN_PAGE: reg_slot = SLOT_WPG;
        `PDSM_OFF_TBL_PAGE: reg_slot = SLOT_TPG;
        `PDSM_OFF_STATUS:   reg_slot = SLOT_STAT;
        default:            reg_slot = SLOT_NONE;
      endcase
    end
  endfunction

  wire is_tbl   = req_valid_i && (req_op_i >= OP_TRDL) && (req_op_i <= OP_TWTH);
  // window gated by table traffic in this cycle or held busy
  wire win_hit  = req_valid_i && !is_tbl && !tbl_busy_q && win_en_q
                  && x_addr_i[15] && (req_op_i == OP_RD || req_op_i == OP_WR);
  wire is_write = req_valid_i && (req_op_i == OP_WR || req_op_i == OP_ACCW);
  // mac x reads cannot reach y space; mac writes can
  wire x_bad    = req_mac_i && !is_write && in_y(x_addr_i);
  wire y_bad    = !in_y(y_addr_i);
  wire bus_go   = hsel_i && hready_i && htrans_i[1];

  reg [1:0]  stall_d;
  reg [15:0] ret;
  reg [7:0]  bret;
  wire [1:0]  lane_be;
  wire [15:0] lane_wdata;

  // byte lanes of the x write bus
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_lane
      // a byte write lands only on the lane its address lsb picks
      assign lane_be[g] = !req_byte_i || (x_addr_i[0] == (g == 1));
      assign lane_wdata[8*g +: 8] = req_byte_i ? wdata_i[7:0] : wdata_i[8*g +: 8];
    end
  endgenerate

  always @* begin
    stall_d = 2'd0;
    if (win_hit) begin
      case (req_rep_i)
        REP_NONE: stall_d = req_short_i ? `PDSM_WAIT_SHORT : `PDSM_WAIT_LONG;
        REP_EDGE: stall_d = `PDSM_WAIT_LONG;
        REP_MID:  stall_d = 2'd0;
        default:  stall_d = `PDSM_WAIT_LONG;
      endcase
    end
  end

  // return data built from this cycle's memory answers, picked by last cycle's request
  always @* begin
    ret = 16'h0000;
    case (sel_q)
      SEL_RAM:  ret = xram_rdata_i;
      SEL_WIN:  ret = prog_rdata_i[15:0];
      SEL_TLO:  ret = prog_rdata_i[15:0];
      SEL_THI:  ret = {8'h00, prog_rdata_i[23:16]};
      SEL_ZERO: ret = 16'h0000;
      default:  ret = 16'h0000;
    endcase
    bret = bsel_q ? ret[15:8] : ret[7:0];
    if (sel_q == SEL_THI)
      bret = bsel_q ? 8'h00 : prog_rdata_i[23:16];
  end

  // register slave: zero wait states, always okay
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      bus_ph_q    <= 1'b0;
      bus_wr_q    <= 1'b0;
      bus_addr_q  <= 12'h000;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else if (ce_i) begin
      hresp_o     <= 1'b0;
      hreadyout_o <= 1'b1;
      bus_ph_q    <= bus_go;
      if (bus_go) begin
        bus_wr_q   <= hwrite_i;
        bus_addr_q <= haddr_i[11:0];
      end
      if (bus_go && !hwrite_i) begin
        case (reg_slot(haddr_i[11:0]))
          SLOT_CTRL: hrdata_o <= {31'h0, win_en_q};
          SLOT_WPG:  hrdata_o <= {24'h0, win_page_q};
          SLOT_TPG:  hrdata_o <= {24'h0, tbl_page_q};
          SLOT_STAT: hrdata_o <= {29'h0, last_win_q, last_tbl_q, tbl_busy_q};
          default:   hrdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // software registers, written in the data phase
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      win_en_q   <= `PDSM_CTRL_RST;
      win_page_q <= `PDSM_PAGE_RST;
      tbl_page_q <= `PDSM_PAGE_RST;
    end else if (ce_i) begin
      if (bus_ph_q && bus_wr_q) begin
        case (reg_slot(bus_addr_q))
          SLOT_CTRL: win_en_q   <= hwdata_i[`PDSM_CTRL_WIN_EN];
          SLOT_WPG:  win_page_q <= hwdata_i[7:0];
          SLOT_TPG:  tbl_page_q <= hwdata_i[7:0];
          default:   ;
        endcase
      end
    end
  end

  // request history and window stall
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      tbl_busy_q <= 1'b0;
      last_win_q <= 1'b0;
      last_tbl_q <= 1'b0;
      stall_o    <= 2'd0;
    end else if (ce_i) begin
      tbl_busy_q <= is_tbl;
      if (req_valid_i) begin
        last_win_q <= win_hit;
        last_tbl_q <= is_tbl;
      end
      stall_o <= stall_d;
    end
  end

  // program port
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      prog_addr_o  <= 24'h000000;
      prog_rd_o    <= 1'b0;
      prog_wr_lo_o <= 1'b0;
      prog_wr_hi_o <= 1'b0;
      prog_wdata_o <= 16'h0000;
    end else if (ce_i) begin
      prog_rd_o    <= 1'b0;
      prog_wr_lo_o <= 1'b0;
      prog_wr_hi_o <= 1'b0;
      prog_wdata_o <= wdata_i;
      if (is_tbl) begin
        // page bit 7 becomes address bit 23: configuration space
        prog_addr_o  <= {tbl_page_q, x_addr_i};
        prog_rd_o    <= (req_op_i == OP_TRDL) || (req_op_i == OP_TRDH);
        prog_wr_lo_o <= (req_op_i == OP_TWTL);
        prog_wr_hi_o <= (req_op_i == OP_TWTH);
      end else if (win_hit) begin
        prog_addr_o <= {1'b0, win_page_q, x_addr_i[14:0]};
        prog_rd_o   <= (req_op_i == OP_RD);
      end
    end
  end

  // x bus: writes below RAM_END that miss the window go here, combined space for write-back
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      xram_addr_o  <= 16'h0000;
      xram_rd_o    <= 1'b0;
      xram_wr_o    <= 1'b0;
      xram_be_o    <= 2'b00;
      xram_wdata_o <= 16'h0000;
      x_bitrev_o   <= 1'b0;
      x_modulo_o   <= 1'b0;
    end else if (ce_i) begin
      xram_addr_o  <= {x_addr_i[15:1], 1'b0};
      xram_wdata_o <= lane_wdata;
      xram_be_o    <= lane_be;
      xram_wr_o    <= is_write && !win_hit && implemented(x_addr_i);
      xram_rd_o    <= req_valid_i && req_op_i == OP_RD && !win_hit && !x_bad
                      && implemented(x_addr_i);
      x_bitrev_o   <= x_bitrev_i && is_write && req_op_i == OP_WR && !in_y(x_addr_i);
      x_modulo_o   <= x_modulo_i && req_valid_i;
    end
  end

  // y bus: read only, mac only
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      yram_addr_o <= 16'h0000;
      yram_rd_o   <= 1'b0;
      y_modulo_o  <= 1'b0;
      yrd_q       <= 1'b0;
      ybad_q      <= 1'b0;
    end else if (ce_i) begin
      yram_addr_o <= {y_addr_i[15:1], 1'b0};
      yram_rd_o   <= req_valid_i && req_mac_i && y_valid_i && !y_bad;
      y_modulo_o  <= y_modulo_i && req_valid_i && req_mac_i && y_valid_i;
      yrd_q       <= req_valid_i && req_mac_i && y_valid_i;
      ybad_q      <= y_bad;
    end
  end

  // answer one cycle after the memories are addressed
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sel_q         <= SEL_ZERO;
      byte_q        <= 1'b0;
      bsel_q        <= 1'b0;
      x_rdata_o     <= 16'h0000;
      y_rdata_o     <= 16'h0000;
      rdata_valid_o <= 1'b0;
    end else if (ce_i) begin
      // a byte flag left on an idle request must not raise the answer strobe
      byte_q <= req_valid_i && req_byte_i;
      bsel_q <= x_addr_i[0];
      if (!req_valid_i)
        sel_q <= SEL_ZERO;
      else if (req_op_i == OP_TRDL)
        sel_q <= SEL_TLO;
      else if (req_op_i == OP_TRDH)
        sel_q <= SEL_THI;
      else if (win_hit)
        sel_q <= SEL_WIN;
      else if (x_bad || !implemented(x_addr_i))
        sel_q <= SEL_ZERO;
      else
        sel_q <= SEL_RAM;

      rdata_valid_o <= sel_q != SEL_ZERO || byte_q || yrd_q;
      x_rdata_o     <= byte_q ? {8'h00, bret} : ret;
      y_rdata_o     <= (yrd_q && !ybad_q) ? yram_rdata_i : 16'h0000;
    end
  end
endmodule

// >>> pdsm_mapper_chk.sv
// assertions on the mapper ports
`timescale 1ns/1ps
module pdsm_mapper_chk (
  input logic        clk_i,
  input logic        rst_n_i,
  input logic        ce_i,
  input logic        req_valid_i,
  input logic [2:0]  req_op_i,
  input logic        req_mac_i,
  input logic        req_short_i,
  input logic [1:0]  req_rep_i,
  input logic        y_valid_i,
  input logic [15:0] x_addr_i,
  input logic [23:0] prog_addr_o,
  input logic        prog_rd_o,
  input logic        xram_rd_o,
  input logic        xram_wr_o,
  input logic        yram_rd_o,
  input logic [1:0]  stall_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire rq = req_valid_i && ce_i;
  wire wr = rq && req_op_i == 3'd0 && x_addr_i[15];
  win_addr_a: assert property (wr |=> !prog_rd_o || (prog_addr_o[23] == 1'b0 &&
    prog_addr_o[14:0] == $past(x_addr_i[14:0]))) else $error("window address wrong");
  no_win_a: assert property (rq && req_op_i == 3'd0 && !x_addr_i[15] |=> !prog_rd_o)
    else $error("program read below window");
  tbl_addr_a: assert property (rq && req_op_i inside {[3'd2:3'd5]} |=>
    prog_addr_o[15:0] == $past(x_addr_i)) else $error("table address wrong");
  tbl_rd_a: assert property (rq && req_op_i inside {3'd2, 3'd3} |=> prog_rd_o && !xram_rd_o)
    else $error("table read not on program port");
  stall_one_a: assert property (wr && req_short_i && req_rep_i == 2'd0 ##1 prog_rd_o
    |-> stall_o == 2'd1) else $error("short window stall wrong");
  stall_two_a: assert property (wr && !req_short_i && req_rep_i == 2'd0 ##1 prog_rd_o
    |-> stall_o == 2'd2) else $error("long window stall wrong");
  stall_rep_a: assert property (wr && req_rep_i != 2'd0 ##1 prog_rd_o
    |-> stall_o == ($past(req_rep_i) == 2'd2 ? 2'd0 : 2'd2)) else $error("repeat stall wrong");
  x_write_a: assert property (rq && req_op_i inside {3'd1, 3'd6} && x_addr_i < 16'h2000 |=>
    xram_wr_o && !yram_rd_o) else $error("write not on x bus");
  y_read_a: assert property (yram_rd_o |-> $past(rq && req_mac_i && y_valid_i))
    else $error("y read outside mac");
endmodule
bind pdsm_mapper pdsm_mapper_chk u_chk (.*);

// >>> pdsm_mem_model.sv
// memories answering the mapper within the cycle of each read strobe
`timescale 1ns/1ps
module pdsm_mem_model (
  input  wire logic        clk_i,
  input  wire logic        prog_rd_o,
  input  wire logic        xram_rd_o,
  input  wire logic        yram_rd_o,
  input  wire logic [23:0] pw,
  input  wire logic [15:0] xw,
  input  wire logic [15:0] yw,
  output logic      [23:0] prog_rdata_i,
  output logic      [15:0] xram_rdata_i,
  output logic      [15:0] yram_rdata_i
);
  logic [23:0] p_last = 24'h0;
  logic [15:0] x_last = 16'h0, y_last = 16'h0;
  // data stands while the strobe does; idle buses show the inverse of their last value
  assign prog_rdata_i = prog_rd_o ? pw : ~p_last;
  assign xram_rdata_i = xram_rd_o ? xw : ~x_last;
  assign yram_rdata_i = yram_rd_o ? yw : ~y_last;
  always @(posedge clk_i) begin
    p_last <= prog_rdata_i;
    x_last <= xram_rdata_i;
    y_last <= yram_rdata_i;
  end
endmodule

// >>> test_program_data_space_mapper.sv
// testbench for the program/data space mapper
`timescale 1ns/1ps
`include "pdsm_map.vh"
module test_program_data_space_mapper;
  logic        clk_i = 0, rst_n_i = 0, ce_i = 1, hwrite_i = 0, hsel_i = 0, req_valid_i = 0;
  logic        req_byte_i = 0, req_mac_i = 0, req_short_i = 0, y_valid_i = 0;
  logic        x_bitrev_i = 0, x_modulo_i = 0, y_modulo_i = 0;
  logic [1:0]  htrans_i = 0, req_rep_i = 0, stall_o, xram_be_o;
  logic [2:0]  hsize_i = 3'h2, req_op_i = 0;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, r;
  logic [15:0] x_addr_i = 0, y_addr_i = 0, wdata_i = 0, xw = 16'h1357, yw = 16'h2468;
  logic [15:0] xr, yr, x_rdata_o, y_rdata_o, xram_rdata_i, yram_rdata_i, xram_addr_o;
  logic [15:0] xram_wdata_o, yram_addr_o, prog_wdata_o;
  logic [23:0] pw = 24'hC3A55A, prog_rdata_i, prog_addr_o;
  logic        hreadyout_o, hresp_o, prog_rd_o, prog_wr_lo_o, prog_wr_hi_o, xram_rd_o;
  logic        xram_wr_o, x_bitrev_o, x_modulo_o, yram_rd_o, y_modulo_o, rdata_valid_o;
  logic [2:0]  top [6] = '{3'd2, 3'd2, 3'd2, 3'd3, 3'd3, 3'd3};
  logic [15:0] tex [6] = '{16'hA55A, 16'h005A, 16'h00A5, 16'h00C3, 16'h00C3, 16'h0000};
  wire         hready_i = hreadyout_o;
  int          error_cnt = 0, checks_done = 0, cyc = 0, i, k;
  pdsm_mapper u_pdsm_mapper (.*);
  pdsm_mem_model u_pdsm_mem_model (.*);
  initial forever #4 clk_i = ~clk_i;
  task chk(input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task ahb(input logic w, input logic [31:0] a, d);
    @(posedge clk_i);
    htrans_i <= 2'b10;
    hsel_i <= 1;
    haddr_i <= a;
    hwrite_i <= w;
    do @(posedge clk_i); while (!hready_i);
    htrans_i <= 2'b00;
    hsel_i <= 0;
    hwdata_i <= d;
    do @(posedge clk_i); while (!hready_i);
    r = hrdata_o;
  endtask
  task core(input logic [2:0] op, input logic b, m, s, input logic [1:0] rp,
            input logic [15:0] xa, ya);
    @(posedge clk_i);
    req_valid_i <= 1;
    req_op_i <= op;
    req_byte_i <= b;
    req_mac_i <= m;
    y_valid_i <= m;
    req_short_i <= s;
    req_rep_i <= rp;
    x_addr_i <= xa;
    y_addr_i <= ya;
    wdata_i <= ~xa;
    @(posedge clk_i);
    req_valid_i <= 0;
    for (i = 0; i < 4 && rdata_valid_o !== 1'b1; i++) @(posedge clk_i);
    xr = x_rdata_o;
    yr = y_rdata_o;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1;
    ahb(0, `PDSM_OFF_WIN_PAGE, 0);
    chk(r, 0);
    ahb(1, `PDSM_OFF_WIN_PAGE, 32'h5A);
    ahb(1, `PDSM_OFF_TBL_PAGE, 32'h83);
    ahb(1, `PDSM_OFF_CTRL, 32'h1);
    ahb(0, `PDSM_OFF_WIN_PAGE, 0);
    chk(r, 32'h5A);
    ahb(0, 32'h10, 0);
    chk(r, 0);
    $display("register test done");
    for (k = 0; k < 6; k++) begin
      core(top[k], k % 3 != 0, 0, 0, 0, {15'h0080, k % 3 == 2}, 0);
      chk(xr, tex[k]);
    end
    for (k = 4; k < 7; k++) core(3'(k), 0, 0, 0, 0, 16'h0A00, 0);
    core(1, 0, 0, 0, 0, 16'h0300, 0);
    $display("table test done");
    for (k = 0; k < 4; k++) begin
      core(0, 0, 0, k == 0, k == 0 ? 2'd0 : 2'(k - 1), 16'h8124, 0);
      chk(xr, 16'hA55A);
    end
    $display("window test done");
    core(0, 0, 1, 1, 0, 16'h0900, 16'h0A00);
    chk(xr, 0);
    chk(yr, yw);
    core(0, 0, 1, 1, 0, 16'h0100, 16'h0200);
    chk(xr, xw);
    chk(yr, 0);
    core(0, 0, 0, 0, 0, 16'h0900, 0);
    chk(xr, xw);
    core(0, 0, 0, 0, 0, 16'h3000, 0);
    chk(xr, 0);
    core(0, 1, 0, 0, 0, 16'h0101, 0);
    chk(xr, {8'h00, xw[15:8]});
    ahb(1, `PDSM_OFF_CTRL, 32'h0);
    core(0, 0, 0, 0, 0, 16'h8124, 0);
    chk(xr, 0);
    $display("data space test done");
    finish_test();
  end
endmodule
